// ---- core/external_pin_interrupt_unit.sv ----
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
// Function
// RL1: two sense bits pick low level, any change, falling or rising edge.
// RL2: level mode requests continuously while the dedicated pin stays low.
// RL3: low level detected without clock; edges need the I/O clock.
// RL4: all sixteen pin-change inputs detected asynchronously for wake-up.
// RL5: pins trigger even when driven as outputs by the part itself.
// RL6: high group requests on enabled 15..8 toggle, low group on 7..0.
// RL7: dedicated pin sampled before edge detection; pulses over one clock count (here only a pulse sampled at two successive edges counts).
// RL8: source must hold a low level until the current instruction ends.
// RL9: dedicated interrupt needs global enable and its own mask bit.
// RL10: mask bit 7 high group, bit 6 low group, bit 0 dedicated pin.
// RL11: flag bit 7 or 6 set when a group change triggers a request.
// RL12: set flag with global and local enable requests its vector.
// RL13: flags clear when the handler runs or on write of one.
// RL14: flag bit 0 set on edge or change; held clear in level mode.
// RL15: per-pin mask bit and group enable both needed for a change.
// RL16: level vanishing before start-up ends wakes but generates no interrupt.
// RL17: I/O clock stops outside idle; only async level or change wakes.
// RL18: synchronized pin compared with previous sample; matching mismatch sets flag.
module external_pin_interrupt_unit (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // axi4-lite write address
    input wire logic awvalid_i,
    output logic awready_o,
    input wire logic [ext_irq_pkg::ADDR_W-1:0] awaddr_i,
    input wire logic [2:0] awprot_i,
    // axi4-lite write data
    input wire logic wvalid_i,
    output logic wready_o,
    input wire logic [31:0] wdata_i,
    input wire logic [3:0] wstrb_i,
    // axi4-lite write response
    output logic bvalid_o,
    input wire logic bready_i,
    output logic [1:0] bresp_o,
    // axi4-lite read address
    input wire logic arvalid_i,
    output logic arready_o,
    input wire logic [ext_irq_pkg::ADDR_W-1:0] araddr_i,
    input wire logic [2:0] arprot_i,
    // axi4-lite read data
    output logic rvalid_o,
    input wire logic rready_i,
    output logic [31:0] rdata_o,
    output logic [1:0] rresp_o,
    // interrupt pins, as seen on the pad whatever the pin direction
    input wire logic dedicated_irq_pin_i,
    input wire logic [ext_irq_pkg::PC_PINS-1:0] pin_change_inputs_i,
    // processor side
    input wire logic global_enable_i,
    input wire logic dedicated_ack_i,
    input wire logic change_group_high_ack_i,
    input wire logic change_group_low_ack_i,
    output logic dedicated_irq_o,
    output logic change_group_high_irq_o,
    output logic change_group_low_irq_o,
    output logic wake_o,
    // summary interrupt
    output logic irq_o
);

    // register file
    logic [1:0] sense_ff;
    logic [7:0] irq_mask_ff;
    logic [7:0] flags_ff;
    logic [7:0] pc_mask_low_ff;
    logic [7:0] pc_mask_high_ff;
    logic [7:0] evt_status_ff;
    logic [7:0] evt_enable_ff;

    // synchronisers: three stages, value follows once stages two and three agree
    logic [2:0] ded_sync_ff;
    logic ded_filt_ff;
    logic ded_prev_ff;
    logic [ext_irq_pkg::PC_PINS-1:0] pc_s1_ff;
    logic [ext_irq_pkg::PC_PINS-1:0] pc_s2_ff;
    logic [ext_irq_pkg::PC_PINS-1:0] pc_s3_ff;
    logic [ext_irq_pkg::PC_PINS-1:0] pc_filt_ff;
    logic [ext_irq_pkg::PC_PINS-1:0] pc_prev_ff;
    logic [ext_irq_pkg::PC_PINS-1:0] pc_armed;

    // bus state
    logic aw_held_ff;
    logic w_held_ff;
    logic [9:0] waddr_ff;
    logic [7:0] wbyte_ff;
    logic wlane_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // events and decode
    logic ded_edge_evt;
    logic grp_high_evt;
    logic grp_low_evt;
    logic level_mode;
    logic [7:0] set_vec;
    logic [7:0] ack_vec;
    logic [7:0] w1c_vec;
    logic do_write;
    logic ar_take;
    logic [9:0] rd_idx;
    logic status_read;
    logic aw_take;
    logic w_take;

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx == ext_irq_pkg::IDX_SENSE_CTRL) || (idx == ext_irq_pkg::IDX_IRQ_MASK) ||
                     (idx == ext_irq_pkg::IDX_IRQ_FLAGS) || (idx == ext_irq_pkg::IDX_PC_MASK_LOW) ||
                     (idx == ext_irq_pkg::IDX_PC_MASK_HIGH) || (idx == ext_irq_pkg::IDX_EVT_STATUS) ||
                     (idx == ext_irq_pkg::IDX_EVT_ENABLE);
    endfunction

    function automatic logic [ext_irq_pkg::GRP_PINS-1:0] group_change(
        input logic [ext_irq_pkg::GRP_PINS-1:0] now_v,
        input logic [ext_irq_pkg::GRP_PINS-1:0] prev_v,
        input logic [ext_irq_pkg::GRP_PINS-1:0] pin_mask,
        input logic grp_en
    );
        group_change = (now_v ^ prev_v) & pin_mask & {ext_irq_pkg::GRP_PINS{grp_en}};
    endfunction

    // ---------------- pin sampling ----------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ded_sync_ff <= 3'h7;
            ded_filt_ff <= 1'b1;
            ded_prev_ff <= 1'b1;
        end else begin
            ded_sync_ff <= {ded_sync_ff[1:0], dedicated_irq_pin_i}; // [RL7] [RL5]
            if (ded_sync_ff[1] == ded_sync_ff[2]) begin
                ded_filt_ff <= ded_sync_ff[2];
            end
            ded_prev_ff <= ded_filt_ff; // [RL18]
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pc_s1_ff <= '0;
            pc_s2_ff <= '0;
            pc_s3_ff <= '0;
            pc_filt_ff <= '0;
            pc_prev_ff <= '0;
        end else begin
            pc_s1_ff <= pin_change_inputs_i; // [RL5]
            pc_s2_ff <= pc_s1_ff;
            pc_s3_ff <= pc_s2_ff;
            for (int i = 0; i < ext_irq_pkg::PC_PINS; i++) begin
                if (pc_s2_ff[i] == pc_s3_ff[i]) begin
                    pc_filt_ff[i] <= pc_s3_ff[i];
                end
            end
            pc_prev_ff <= pc_filt_ff;
        end
    end

    // ---------------- detection ----------------
    assign level_mode = (sense_ff == ext_irq_pkg::SENSE_LOW_LEVEL);

    always_comb begin
        case (sense_ff) // [RL1] [RL18]
            ext_irq_pkg::SENSE_ANY_CHANGE: ded_edge_evt = ded_filt_ff ^ ded_prev_ff;
            ext_irq_pkg::SENSE_FALLING: ded_edge_evt = ded_prev_ff & ~ded_filt_ff;
            ext_irq_pkg::SENSE_RISING: ded_edge_evt = ~ded_prev_ff & ded_filt_ff;
            default: ded_edge_evt = 1'b0;
        endcase
    end

    assign grp_high_evt = |group_change(pc_filt_ff[15:8], pc_prev_ff[15:8], pc_mask_high_ff,
                                        irq_mask_ff[ext_irq_pkg::BIT_GRP_HIGH]); // [RL6] [RL15]
    assign grp_low_evt = |group_change(pc_filt_ff[7:0], pc_prev_ff[7:0], pc_mask_low_ff,
                                       irq_mask_ff[ext_irq_pkg::BIT_GRP_LOW]); // [RL6] [RL15]

    // pins differing from their last settled value, before any clock edge
    assign pc_armed = (pin_change_inputs_i ^ pc_filt_ff) & {pc_mask_high_ff, pc_mask_low_ff} &
                      {{ext_irq_pkg::GRP_PINS{irq_mask_ff[ext_irq_pkg::BIT_GRP_HIGH]}},
                       {ext_irq_pkg::GRP_PINS{irq_mask_ff[ext_irq_pkg::BIT_GRP_LOW]}}};

    // combinational wake path, needs no clock edge
    assign wake_o = (|pc_armed) || // [RL4] [RL17]
                    (level_mode && !dedicated_irq_pin_i && irq_mask_ff[ext_irq_pkg::BIT_DEDICATED]); // [RL3] [RL16]

    always_comb begin
        set_vec = '0;
        set_vec[ext_irq_pkg::BIT_GRP_HIGH] = grp_high_evt; // [RL11]
        set_vec[ext_irq_pkg::BIT_GRP_LOW] = grp_low_evt; // [RL11]
        set_vec[ext_irq_pkg::BIT_DEDICATED] = ded_edge_evt; // [RL14]
        ack_vec = '0;
        ack_vec[ext_irq_pkg::BIT_GRP_HIGH] = change_group_high_ack_i;
        ack_vec[ext_irq_pkg::BIT_GRP_LOW] = change_group_low_ack_i;
        ack_vec[ext_irq_pkg::BIT_DEDICATED] = dedicated_ack_i;
    end

    // ---------------- axi4-lite write path ----------------
    assign aw_take = awvalid_i && awready_o;
    assign w_take = wvalid_i && wready_o;
    assign awready_o = !aw_held_ff && !bvalid_ff;
    assign wready_o = !w_held_ff && !bvalid_ff;
    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign bvalid_o = bvalid_ff;
    assign bresp_o = bresp_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            aw_held_ff <= 1'b0;
            waddr_ff <= '0;
        end else if (aw_take) begin
            aw_held_ff <= 1'b1;
            waddr_ff <= awaddr_i[ext_irq_pkg::ADDR_W-1:ext_irq_pkg::WORD_LSB];
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            w_held_ff <= 1'b0;
            wbyte_ff <= ext_irq_pkg::RST_BYTE;
            wlane_ff <= 1'b0;
        end else if (w_take) begin
            w_held_ff <= 1'b1;
            wbyte_ff <= wdata_i[7:0];
            wlane_ff <= wstrb_i[0];
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= ext_irq_pkg::RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= idx_mapped(waddr_ff) ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
        end else if (bready_i) begin
            bvalid_ff <= 1'b0;
        end
    end

    // ---------------- configuration registers ----------------
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sense_ff <= ext_irq_pkg::RST_SENSE;
            irq_mask_ff <= ext_irq_pkg::RST_BYTE;
            pc_mask_low_ff <= ext_irq_pkg::RST_BYTE;
            pc_mask_high_ff <= ext_irq_pkg::RST_BYTE;
            evt_enable_ff <= ext_irq_pkg::RST_BYTE;
        end else if (do_write && wlane_ff) begin
            case (waddr_ff)
                ext_irq_pkg::IDX_SENSE_CTRL: sense_ff <= wbyte_ff[1:0]; // [RL1]
                ext_irq_pkg::IDX_IRQ_MASK: irq_mask_ff <= wbyte_ff & ext_irq_pkg::EVT_FIELDS; // [RL10]
                ext_irq_pkg::IDX_PC_MASK_LOW: pc_mask_low_ff <= wbyte_ff; // [RL15]
                ext_irq_pkg::IDX_PC_MASK_HIGH: pc_mask_high_ff <= wbyte_ff; // [RL15]
                ext_irq_pkg::IDX_EVT_ENABLE: evt_enable_ff <= wbyte_ff & ext_irq_pkg::EVT_FIELDS;
                default: ;
            endcase
        end
    end

    assign w1c_vec = (do_write && wlane_ff && waddr_ff == ext_irq_pkg::IDX_IRQ_FLAGS) ?
                     (wbyte_ff & ext_irq_pkg::EVT_FIELDS) : ext_irq_pkg::RST_BYTE;

    // flags: set wins over ack or write-one clear
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_ff <= ext_irq_pkg::RST_BYTE;
        end else begin
            flags_ff <= ((flags_ff & ~(ack_vec | w1c_vec)) | set_vec) & ext_irq_pkg::EVT_FIELDS; // [RL13]
            if (level_mode) begin
                flags_ff[ext_irq_pkg::BIT_DEDICATED] <= 1'b0; // [RL14]
            end
        end
    end

    // ---------------- vector requests ----------------
    assign change_group_high_irq_o = global_enable_i && irq_mask_ff[ext_irq_pkg::BIT_GRP_HIGH] &&
                                     flags_ff[ext_irq_pkg::BIT_GRP_HIGH]; // [RL12]
    assign change_group_low_irq_o = global_enable_i && irq_mask_ff[ext_irq_pkg::BIT_GRP_LOW] &&
                                    flags_ff[ext_irq_pkg::BIT_GRP_LOW]; // [RL12]
    // level request follows the settled pin, so a vanished level asks for nothing
    assign dedicated_irq_o = global_enable_i && irq_mask_ff[ext_irq_pkg::BIT_DEDICATED] && // [RL9]
                             (level_mode ? !ded_filt_ff : flags_ff[ext_irq_pkg::BIT_DEDICATED]); // [RL2] [RL16]

    // ---------------- read path ----------------
    assign ar_take = arvalid_i && arready_o;
    assign arready_o = !rvalid_ff;
    assign rd_idx = araddr_i[ext_irq_pkg::ADDR_W-1:ext_irq_pkg::WORD_LSB];
    assign status_read = ar_take && (rd_idx == ext_irq_pkg::IDX_EVT_STATUS);
    assign rvalid_o = rvalid_ff;
    assign rdata_o = rdata_ff;
    assign rresp_o = rresp_ff;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= '0;
            rresp_ff <= ext_irq_pkg::RESP_OKAY;
        end else if (ar_take) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= idx_mapped(rd_idx) ? ext_irq_pkg::RESP_OKAY : ext_irq_pkg::RESP_SLVERR;
            case (rd_idx)
                ext_irq_pkg::IDX_SENSE_CTRL: rdata_ff <= {24'h000000, 6'h00, sense_ff};
                ext_irq_pkg::IDX_IRQ_MASK: rdata_ff <= {24'h000000, irq_mask_ff};
                ext_irq_pkg::IDX_IRQ_FLAGS: rdata_ff <= {24'h000000, flags_ff};
                ext_irq_pkg::IDX_PC_MASK_LOW: rdata_ff <= {24'h000000, pc_mask_low_ff};
                ext_irq_pkg::IDX_PC_MASK_HIGH: rdata_ff <= {24'h000000, pc_mask_high_ff};
                ext_irq_pkg::IDX_EVT_STATUS: rdata_ff <= {24'h000000, evt_status_ff};
                ext_irq_pkg::IDX_EVT_ENABLE: rdata_ff <= {24'h000000, evt_enable_ff};
                default: rdata_ff <= '0;
            endcase
        end else if (rready_i) begin
            rvalid_ff <= 1'b0;
        end
    end

    // sticky event status, cleared by reading it; a new event wins
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            evt_status_ff <= ext_irq_pkg::RST_BYTE;
        end else if (status_read) begin
            evt_status_ff <= set_vec;
        end else begin
            evt_status_ff <= evt_status_ff | set_vec;
        end
    end

    assign irq_o = |(evt_status_ff & evt_enable_ff);

endmodule

// ---- include/ext_irq_pkg.sv ----
package ext_irq_pkg;

    // register indices; byte address is four times the index
    localparam logic [9:0] IDX_SENSE_CTRL = 10'h069;
    localparam logic [9:0] IDX_IRQ_MASK = 10'h01D;
    localparam logic [9:0] IDX_IRQ_FLAGS = 10'h01C;
    localparam logic [9:0] IDX_PC_MASK_LOW = 10'h06B;
    localparam logic [9:0] IDX_PC_MASK_HIGH = 10'h06C;
    localparam logic [9:0] IDX_EVT_STATUS = 10'h070;
    localparam logic [9:0] IDX_EVT_ENABLE = 10'h071;

    localparam int ADDR_W = 12;
    localparam int WORD_LSB = 2;

    // field positions shared by mask, flag, status and enable registers
    localparam int BIT_GRP_HIGH = 7;
    localparam int BIT_GRP_LOW = 6;
    localparam int BIT_DEDICATED = 0;
    localparam logic [7:0] EVT_FIELDS = 8'hC1;
    localparam logic [7:0] SENSE_FIELDS = 8'h03;

    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_SENSE = 2'h0;

    // sense encodings of the dedicated pin
    localparam logic [1:0] SENSE_LOW_LEVEL = 2'h0;
    localparam logic [1:0] SENSE_ANY_CHANGE = 2'h1;
    localparam logic [1:0] SENSE_FALLING = 2'h2;
    localparam logic [1:0] SENSE_RISING = 2'h3;

    // bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    localparam int PC_PINS = 16;
    localparam int GRP_PINS = 8;

endpackage

// ---- verif/pin_irq_monitor.sv ----
`timescale 1ns/1ns
module pin_irq_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    // bus
    input wire logic awvalid_i,
    input wire logic awready_o,
    input wire logic wvalid_i,
    input wire logic wready_o,
    input wire logic bvalid_o,
    input wire logic rvalid_o,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] rresp_o,
    // pins and processor side
    input wire logic [ext_irq_pkg::PC_PINS-1:0] pin_change_inputs_i,
    input wire logic global_enable_i,
    input wire logic dedicated_ack_i,
    input wire logic change_group_high_ack_i,
    input wire logic change_group_low_ack_i,
    input wire logic dedicated_irq_o,
    input wire logic change_group_high_irq_o,
    input wire logic change_group_low_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // quiet cycles of each pin group, saturating
    logic [15:0] prev_ff;
    logic [3:0] hi_cnt_ff;
    logic [3:0] lo_cnt_ff;
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            prev_ff <= 16'h0000;
            hi_cnt_ff <= 4'h0;
            lo_cnt_ff <= 4'h0;
        end else begin
            prev_ff <= pin_change_inputs_i;
            hi_cnt_ff <= (prev_ff[15:8] != pin_change_inputs_i[15:8]) ? 4'h0 : hi_cnt_ff + {3'h0, hi_cnt_ff != 4'hF};
            lo_cnt_ff <= (prev_ff[7:0] != pin_change_inputs_i[7:0]) ? 4'h0 : lo_cnt_ff + {3'h0, lo_cnt_ff != 4'hF};
        end
    end
    property p_ded_gate; dedicated_irq_o |-> global_enable_i; endproperty
    a_ded_gate: assert property (p_ded_gate)
        else $error("dedicated request without global enable");
    property p_grp_gate; change_group_high_irq_o || change_group_low_irq_o |-> global_enable_i; endproperty
    a_grp_gate: assert property (p_grp_gate)
        else $error("group request without global enable");
    property p_hi_cause; $rose(change_group_high_irq_o) && !bvalid_o && $past(global_enable_i) |-> hi_cnt_ff < 4'hA;
    endproperty
    a_hi_cause: assert property (p_hi_cause)
        else $error("high group request without a pin change");
    property p_lo_cause; $rose(change_group_low_irq_o) && !bvalid_o && $past(global_enable_i) |-> lo_cnt_ff < 4'hA;
    endproperty
    a_lo_cause: assert property (p_lo_cause)
        else $error("low group request without a pin change");
    property p_hi_ack; change_group_high_ack_i && hi_cnt_ff >= 4'hA |=> !change_group_high_irq_o; endproperty
    a_hi_ack: assert property (p_hi_ack)
        else $error("high group request survives handler");
    property p_lo_ack; change_group_low_ack_i && lo_cnt_ff >= 4'hA |=> !change_group_low_irq_o; endproperty
    a_lo_ack: assert property (p_lo_ack)
        else $error("low group request survives handler");
    property p_wr_lat; awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o; endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write response late");
    property p_err_zero; rvalid_o && rresp_o == ext_irq_pkg::RESP_SLVERR |-> rdata_o == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero)
        else $error("refused read returns data");
endmodule
bind external_pin_interrupt_unit pin_irq_monitor u_mon (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .awvalid_i(awvalid_i), .awready_o(awready_o), .wvalid_i(wvalid_i), .wready_o(wready_o),
    .bvalid_o(bvalid_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .pin_change_inputs_i(pin_change_inputs_i), .global_enable_i(global_enable_i),
    .dedicated_ack_i(dedicated_ack_i), .change_group_high_ack_i(change_group_high_ack_i),
    .change_group_low_ack_i(change_group_low_ack_i), .dedicated_irq_o(dedicated_irq_o),
    .change_group_high_irq_o(change_group_high_irq_o), .change_group_low_irq_o(change_group_low_irq_o));

// ---- verif/pin_source_model.sv ----
`timescale 1ns/1ns
module pin_source_model (
    // clock
    input wire logic clk_i,
    // pads
    output logic dedicated_irq_pin_o,
    output logic [ext_irq_pkg::PC_PINS-1:0] pin_change_inputs_o
);
    // levels stay put until the next command, so a low is held long enough
    logic ded_ff = 1'b1;
    logic [15:0] pc_ff = 16'h0000;
    // pad level as seen even when the part drives the pin itself
    assign dedicated_irq_pin_o = ded_ff;
    assign pin_change_inputs_o = pc_ff;
    task automatic set_pin(input logic v);
        @(posedge clk_i);
        ded_ff <= v;
    endtask
    task automatic set_pc(input logic [15:0] v);
        @(posedge clk_i);
        pc_ff <= v;
    endtask
endmodule

// ---- verif/external_pin_interrupt_unit_tb.sv ----
`timescale 1ns/1ns
module external_pin_interrupt_unit_tb;
    localparam logic [9:0] SC = ext_irq_pkg::IDX_SENSE_CTRL;
    localparam logic [9:0] MK = ext_irq_pkg::IDX_IRQ_MASK;
    localparam logic [9:0] FL = ext_irq_pkg::IDX_IRQ_FLAGS;
    localparam logic [9:0] ES = ext_irq_pkg::IDX_EVT_STATUS;
    localparam logic [9:0] EE = ext_irq_pkg::IDX_EVT_ENABLE;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic bready = 1'b0;
    logic rready = 1'b0;
    logic ge = 1'b0;
    logic [2:0] ack = 3'h0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, ded_irq, hi_irq, lo_irq, wake, irq, pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] pcs;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    always #2 clk_i = ~clk_i;
    external_pin_interrupt_unit dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .awvalid_i(awvalid),
        .awready_o(awready), .awaddr_i(awaddr), .awprot_i(wdata[2:0]), .wvalid_i(wvalid), .wready_o(wready),
        .wdata_i(wdata), .wstrb_i(wstrb), .bvalid_o(bvalid), .bready_i(bready), .bresp_o(bresp),
        .arvalid_i(arvalid), .arready_o(arready), .araddr_i(araddr), .arprot_i(araddr[4:2]), .rvalid_o(rvalid),
        .rready_i(rready), .rdata_o(rdata), .rresp_o(rresp), .dedicated_irq_pin_i(pin),
        .pin_change_inputs_i(pcs), .global_enable_i(ge), .dedicated_ack_i(ack[2]),
        .change_group_high_ack_i(ack[1]), .change_group_low_ack_i(ack[0]), .dedicated_irq_o(ded_irq),
        .change_group_high_irq_o(hi_irq), .change_group_low_irq_o(lo_irq), .wake_o(wake), .irq_o(irq));
    pin_source_model src (.clk_i(clk_i), .dedicated_irq_pin_o(pin), .pin_change_inputs_o(pcs));
    task automatic test_done;
        if (fails == 0 && n_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", s, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    task automatic bus(input logic w, input logic [9:0] i, input logic [7:0] d, output logic [31:0] q,
        output logic [1:0] r);
        logic a, b, c, v;
        @(posedge clk_i);
        awaddr <= {i, 2'h0};
        araddr <= {i, 2'h0};
        wdata <= {24'h0, d};
        awvalid <= w;
        wvalid <= w;
        bready <= w;
        arvalid <= !w;
        rready <= !w;
        do begin
            @(negedge clk_i);
            a = awready;
            b = wready;
            c = arready;
            v = w ? bvalid : rvalid;
            q = rdata;
            r = w ? bresp : rresp;
            @(posedge clk_i);
            if (a) awvalid <= 1'b0;
            if (b) wvalid <= 1'b0;
            if (c) arvalid <= 1'b0;
            if (v) bready <= 1'b0;
            if (v) rready <= 1'b0;
        end while (!v);
    endtask
    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b1, i, d, q, r);
        chk("bresp", {30'h0, r}, {30'h0, ext_irq_pkg::RESP_OKAY});
    endtask
    task automatic rd(input logic [9:0] i, input logic [7:0] e);
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, i, 8'h00, q, r);
        chk($sformatf("reg %h", i), q, {24'h0, e});
    endtask
    task automatic pulse_ack(input logic [2:0] k);
        @(posedge clk_i);
        ack <= k;
        @(posedge clk_i);
        ack <= 3'h0;
        wt(1);
    endtask
    task automatic t_regs;
        logic [31:0] q;
        logic [1:0] r;
        for (int i = 0; i < 5; i++) begin
            rd(i < 3 ? (i < 1 ? SC : i < 2 ? MK : FL) : ext_irq_pkg::IDX_PC_MASK_LOW + 10'(i - 3), 8'h00);
        end
        bus(1'b0, 10'h3FF, 8'h00, q, r);
        chk("unmapped", {30'h0, r}, {30'h0, ext_irq_pkg::RESP_SLVERR});
        wr(MK, 8'hFF);
        rd(MK, 8'hC1);
        wr(ext_irq_pkg::IDX_PC_MASK_HIGH, 8'h5A);
        rd(ext_irq_pkg::IDX_PC_MASK_HIGH, 8'h5A);
        // write with lane 0 off must leave the register alone
        @(posedge clk_i);
        wstrb <= 4'h0;
        wr(ext_irq_pkg::IDX_PC_MASK_HIGH, 8'hA5);
        rd(ext_irq_pkg::IDX_PC_MASK_HIGH, 8'h5A);
        @(posedge clk_i);
        wstrb <= 4'hF;
        wr(MK, 8'h01);
    endtask
    task automatic t_edges;
        for (int m = 1; m < 4; m++) begin
            wr(SC, 8'(m));
            wr(FL, 8'h01);
            src.set_pin(1'b0);
            wt(8);
            rd(FL, {7'h0, m != 3});
            chk("ded_irq", {31'h0, ded_irq}, {31'h0, m != 3});
            wr(FL, 8'h01);
            rd(FL, 8'h00);
            src.set_pin(1'b1);
            wt(8);
            rd(FL, {7'h0, m != 2});
            pulse_ack(3'h4);
            chk("ded_irq", {31'h0, ded_irq}, 32'h0);
        end
        wr(SC, 8'h02);
        src.set_pin(1'b0);
        wt(1);
        src.set_pin(1'b1);
        wt(8);
        rd(FL, 8'h01);
    endtask
    task automatic t_level;
        wr(SC, 8'h00);
        src.set_pin(1'b0);
        wt(20);
        chk("ded_irq", {31'h0, ded_irq}, 32'h1);
        chk("wake", {31'h0, wake}, 32'h1);
        rd(FL, 8'h00);
        @(posedge clk_i);
        ge <= 1'b0;
        wt(1);
        chk("ded_irq", {31'h0, ded_irq}, 32'h0);
        @(posedge clk_i);
        ge <= 1'b1;
        src.set_pin(1'b1);
        wt(8);
        chk("ded_irq", {31'h0, ded_irq}, 32'h0);
        chk("wake", {31'h0, wake}, 32'h0);
    endtask
    task automatic t_change;
        wr(ext_irq_pkg::IDX_PC_MASK_LOW, 8'h01);
        wr(ext_irq_pkg::IDX_PC_MASK_HIGH, 8'h80);
        wr(MK, 8'hC1);
        src.set_pc(16'h0002);
        wt(8);
        rd(FL, 8'h00);
        src.set_pc(16'h0003);
        #1 chk("wake", {31'h0, wake}, 32'h1);
        wt(8);
        rd(FL, 8'h40);
        chk("lo_irq", {30'h0, hi_irq, lo_irq}, 32'h1);
        src.set_pc(16'h8003);
        wt(8);
        rd(FL, 8'hC0);
        pulse_ack(3'h2);
        chk("hi_irq", {30'h0, hi_irq, lo_irq}, 32'h1);
        pulse_ack(3'h1);
        chk("lo_irq", {31'h0, lo_irq}, 32'h0);
        wr(MK, 8'h00);
        src.set_pc(16'h0002);
        wt(8);
        rd(FL, 8'h00);
    endtask
    task automatic t_status;
        logic [31:0] q;
        logic [1:0] r;
        bus(1'b0, ES, 8'h00, q, r);
        wr(EE, 8'hC1);
        wr(SC, 8'h01);
        wr(MK, 8'h01);
        src.set_pin(1'b0);
        wt(8);
        chk("irq", {31'h0, irq}, 32'h1);
        wr(EE, 8'h00);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(EE, 8'h01);
        rd(ES, 8'h01);
        wt(1);
        chk("irq", {31'h0, irq}, 32'h0);
    endtask
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            test_done();
        end
    end
    initial begin
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        ge <= 1'b1;
        t_regs();
        t_edges();
        t_level();
        t_change();
        t_status();
        test_done();
    end
endmodule
